// ==== phy_ctrl_defs.svh ====
// register offsets, field positions, reset values and timing counts of the
// reset, indicator and compliance test control bank.
// assumes a 32-bit axi4-lite slave, word aligned registers, 50 MHz aclk.
`ifndef PHY_CTRL_DEFS_SVH
`define PHY_CTRL_DEFS_SVH

// ----------------------------------------------------------------------------
// register indexes (printed offsets are word indexes, byte address is 4x)
// ----------------------------------------------------------------------------
`define IDX_STATUS_BASIC 8'h01
`define IDX_SELF_TEST_ERR 8'h1b
`define IDX_RESET_CONTROL 8'h1f
`define IDX_INDICATOR_CONTROL 8'h25
`define IDX_COMPLIANCE_TEST 8'h27
`define IDX_STRAP_STATUS 8'h30

// ----------------------------------------------------------------------------
// fields
// ----------------------------------------------------------------------------
`define RST_SOFT_BIT 15
`define RST_DIGITAL_BIT 14
`define IND_POL_BIT 9
`define IND_SRC_LSB 3
`define IND_ROUTE_LSB 0
`define CT_ENABLE_BIT 4
`define CT_PATTERN_LSB 0
`define IND_ROUTE_COL 2'h0
`define IND_ROUTE_PIN 2'h3
`define SELF_TEST_CLEAR_BIT 15

// ----------------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------------
`define RST_CONTROL_RESET 16'h0000
`define IND_CONTROL_RESET 16'h0000
`define CT_CONTROL_RESET 16'h0000
`define RESET_PULSE_NS 320
`define CLK_PERIOD_NS 20
`define RESET_PULSE_CYCLES ((`RESET_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BLINK_HALF_CYCLES 24'h2625a0

`endif

// ==== phy_ctrl_pkg.sv ====
// types of the reset, indicator and compliance test control bank.
// assumes phy_ctrl_defs.svh for the numbers.
package phy_ctrl_pkg;

  // --------------------------------------------------------------------------
  // transceiver status carried into the bank
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic link_good;
    logic rx_active;
    logic tx_active;
    logic collision;
    logic speed_100;
    logic full_duplex;
    logic low_power_idle;
    logic mii_error;
    logic pattern_error;
  } phy_status_type;

  typedef enum logic [1:0] {
    RESET_IDLE = 2'h0,
    RESET_RUN = 2'h1,
    RESET_DONE = 2'h3
  } reset_state_type;

  typedef enum logic [1:0] {
    AXI_IDLE = 2'h0,
    AXI_WRITE_RESP = 2'h1,
    AXI_READ_RESP = 2'h3
  } axi_state_type;

  typedef struct packed {
    logic [3:0] source;
    logic polarity_high;
    logic [1:0] route;
  } indicator_cfg_type;

endpackage : phy_ctrl_pkg

// ==== reset_pulser.sv ====
// stretches a one-cycle reset request into a fixed-length reset pulse.
// assumes start is a same-clock pulse.
`timescale 1ns/1ns
`default_nettype none
`include "phy_ctrl_defs.svh"

module reset_pulser (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  output logic busy
);

  typedef struct packed {
    phy_ctrl_pkg::reset_state_type state;
    logic [4:0] count;
  } pulser_state_type;

  localparam logic [4:0] PULSE_LEN = 5'(`RESET_PULSE_CYCLES);

  pulser_state_type s_q;
  pulser_state_type s_d;

  always_comb begin
    s_d = s_q;
    case (s_q.state)
      phy_ctrl_pkg::RESET_IDLE: begin
        if (start) begin
          s_d.state = phy_ctrl_pkg::RESET_RUN;
          s_d.count = PULSE_LEN;
        end
      end
      phy_ctrl_pkg::RESET_RUN: begin
        s_d.count = s_q.count - 5'h01;
        if (s_q.count == 5'h01) begin
          s_d.state = phy_ctrl_pkg::RESET_DONE;
        end
      end
      phy_ctrl_pkg::RESET_DONE: begin
        s_d.state = phy_ctrl_pkg::RESET_IDLE;
      end
      default: begin
        s_d.state = phy_ctrl_pkg::RESET_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '{state: phy_ctrl_pkg::RESET_IDLE, count: 5'h00};
    end else begin
      s_q <= s_d;
    end
  end

  assign busy = (s_q.state == phy_ctrl_pkg::RESET_RUN);

endmodule : reset_pulser
`default_nettype wire

// ==== indicator_mux.sv ====
// picks the multi-function indicator source, applies blink and latch modes.
// assumes status inputs are already in the aclk domain.
`timescale 1ns/1ns
`default_nettype none
`include "phy_ctrl_defs.svh"

module indicator_mux (
  input wire logic aclk,
  input wire logic aresetn,
  input wire phy_ctrl_pkg::phy_status_type status,
  input wire logic [3:0] source,
  input wire logic status_read,
  input wire logic error_count_clear,
  output logic indicator
);

  typedef struct packed {
    logic [23:0] blink_count;
    logic blink;
    logic link_lost;
    logic link_prev;
    logic pattern_err;
    logic [23:0] stretch;
  } mux_state_type;

  mux_state_type s_q;
  mux_state_type s_d;
  logic activity;

  always_comb begin
    activity = status.rx_active | status.tx_active;
    s_d = s_q;
    s_d.link_prev = status.link_good;
    if (s_q.blink_count == 24'h000000) begin
      s_d.blink_count = `BLINK_HALF_CYCLES;
      s_d.blink = ~s_q.blink;
    end else begin
      s_d.blink_count = s_q.blink_count - 24'h000001;
    end
    if (activity) begin
      s_d.stretch = `BLINK_HALF_CYCLES;
    end else if (s_q.stretch != 24'h000000) begin
      s_d.stretch = s_q.stretch - 24'h000001;
    end
    // a drop in the same cycle as the read wins, so no loss goes unseen
    if (s_q.link_prev && !status.link_good) begin
      s_d.link_lost = 1'b1;
    end else if (status_read) begin
      s_d.link_lost = 1'b0;
    end
    if (status.pattern_error) begin
      s_d.pattern_err = 1'b1;
    end else if (error_count_clear) begin
      s_d.pattern_err = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    case (source)
      4'h0: indicator = status.link_good;
      4'h1: indicator = activity;
      4'h2: indicator = status.tx_active;
      4'h3: indicator = status.rx_active;
      4'h4: indicator = status.collision;
      4'h5: indicator = status.speed_100;
      4'h6: indicator = ~status.speed_100;
      4'h7: indicator = status.full_duplex;
      4'h8: indicator = status.link_good & ~(activity & s_q.blink);
      4'h9: indicator = (s_q.stretch != 24'h000000);
      4'ha: indicator = status.link_good & status.speed_100 & status.full_duplex;
      4'hb: indicator = status.low_power_idle;
      4'hc: indicator = status.mii_error;
      4'hd: indicator = s_q.link_lost;
      4'he: indicator = s_q.pattern_err & s_q.blink;
      default: indicator = 1'b0;
    endcase
  end

endmodule : indicator_mux
`default_nettype wire

// ==== phy_reset_led_test_ctrl.sv ====
// reset, multi-function indicator and compliance test control registers.
// assumes an axi4-lite master on aclk; status and strap inputs come from pins
// or other logic and are synchronised here.
//
// Functional notes
// - software reset acts like reset pin, self-clears
// - digital restart keeps registers, then self-clears
// - polarity reset value follows the strap pin; here it loads the inverted strap
// - polarity 0 drives low, 1 drives high
// - source codes 0-7 select basic link signals
// - source codes 8-14 select extended signals
// - link-lost latches until basic status read
// - pattern error latches until counter cleared
// - route 00 to collision, 11 to pin
// - enable bit starts 10 Mbps test pattern
// - low four bits choose 10 Mbps pattern
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "phy_ctrl_defs.svh"

module phy_reset_led_test_ctrl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic polarity_strap,
  input wire phy_ctrl_pkg::phy_status_type phy_status,
  output logic transceiver_reset,
  output logic digital_restart,
  output logic collision_pin,
  output logic first_indicator_pin,
  output logic test_pattern_enable,
  output logic [3:0] test_pattern_select
);

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  typedef struct packed {
    phy_ctrl_pkg::axi_state_type axi;
    logic aw_held;
    logic [7:0] aw_index;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [1:0] bresp;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [15:0] ind_ctrl;
    logic [15:0] ct_ctrl;
    logic [13:0] rst_spare;
    logic [1:0] strap_wait;
    logic [1:0] strap_sync;
    logic [1:0] status_sync_a;
    logic [1:0] status_sync_b;
    logic col_out;
    logic pin_out;
    logic soft_busy;
    logic dig_busy;
  } ctrl_state_type;

  ctrl_state_type s_q;
  ctrl_state_type s_d;

  // status lines come from other domains: two flops before any use
  phy_ctrl_pkg::phy_status_type status_meta_q;
  phy_ctrl_pkg::phy_status_type status_q;

  logic soft_start;
  logic dig_start;
  logic soft_busy;
  logic dig_busy;
  logic status_read;
  logic err_clear;
  logic indicator_raw;
  logic indicator_out;
  logic write_fire;
  logic [15:0] wmask;

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  function automatic logic index_mapped(input logic [7:0] idx);
    index_mapped = (idx == `IDX_RESET_CONTROL) || (idx == `IDX_INDICATOR_CONTROL) ||
                   (idx == `IDX_COMPLIANCE_TEST) || (idx == `IDX_STRAP_STATUS);
  endfunction : index_mapped

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] val,
                                        input logic [15:0] mask);
    merge = (old & ~mask) | (val & mask);
  endfunction : merge

  // --------------------------------------------------------------------------
  // sub-blocks
  // --------------------------------------------------------------------------
  reset_pulser u_soft_reset (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(soft_start),
    .busy(soft_busy)
  );

  // the digital restart pulser is reset by the soft reset too: a full reset
  // covers the restart sequence
  reset_pulser u_digital_restart (
    .aclk(aclk),
    .aresetn(aresetn & ~s_q.soft_busy),
    .start(dig_start),
    .busy(dig_busy)
  );

  indicator_mux u_indicator (
    .aclk(aclk),
    .aresetn(aresetn & ~s_q.soft_busy & ~s_q.dig_busy),
    .status(status_q),
    .source(s_q.ind_ctrl[`IND_SRC_LSB +: 4]),
    .status_read(status_read),
    .error_count_clear(err_clear),
    .indicator(indicator_raw)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_meta_q <= '0;
      status_q <= '0;
    end else begin
      status_meta_q <= phy_status;
      status_q <= status_meta_q;
    end
  end

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    soft_start = 1'b0;
    dig_start = 1'b0;
    status_read = 1'b0;
    err_clear = 1'b0;
    write_fire = 1'b0;
    wmask = {{8{s_q.wstrb[1]}}, {8{s_q.wstrb[0]}}};
    s_d.soft_busy = soft_busy;
    s_d.dig_busy = dig_busy;
    s_d.strap_sync = {s_q.strap_sync[0], polarity_strap};

    // catch the strap only once it has crossed both synchroniser flops;
    // taking it earlier would load the flops' reset value instead
    if (s_q.strap_wait != 2'h3) begin
      s_d.strap_wait = s_q.strap_wait + 2'h1;
      if (s_q.strap_wait == 2'h2) begin
        s_d.ind_ctrl[`IND_POL_BIT] = ~s_q.strap_sync[1];
      end
    end

    if (s_axi_awvalid && !s_q.aw_held && s_q.axi == phy_ctrl_pkg::AXI_IDLE) begin
      s_d.aw_held = 1'b1;
      s_d.aw_index = s_axi_awaddr[9:2];
    end
    if (s_axi_wvalid && !s_q.w_held && s_q.axi == phy_ctrl_pkg::AXI_IDLE) begin
      s_d.w_held = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end

    case (s_q.axi)
      phy_ctrl_pkg::AXI_IDLE: begin
        if (s_q.aw_held && s_q.w_held) begin
          write_fire = 1'b1;
          s_d.aw_held = 1'b0;
          s_d.w_held = 1'b0;
          s_d.axi = phy_ctrl_pkg::AXI_WRITE_RESP;
          s_d.bresp = index_mapped(s_q.aw_index) ? 2'h0 : 2'h2;
        end else if (s_axi_arvalid) begin
          s_d.axi = phy_ctrl_pkg::AXI_READ_RESP;
          s_d.rresp = index_mapped(s_axi_araddr[9:2]) ? 2'h0 : 2'h2;
          s_d.rdata = 32'h00000000;
          case (s_axi_araddr[9:2])
            `IDX_RESET_CONTROL: s_d.rdata[15:0] =
              {s_q.soft_busy, s_q.dig_busy, s_q.rst_spare};
            `IDX_INDICATOR_CONTROL: s_d.rdata[15:0] = s_q.ind_ctrl;
            `IDX_COMPLIANCE_TEST: s_d.rdata[15:0] = s_q.ct_ctrl;
            `IDX_STRAP_STATUS: s_d.rdata[0] = s_q.strap_sync[1];
            default: s_d.rdata = 32'h00000000;
          endcase
          // the basic status register lives elsewhere; only the read is seen
          status_read = (s_axi_araddr[9:2] == `IDX_STATUS_BASIC);
        end
      end
      phy_ctrl_pkg::AXI_WRITE_RESP: begin
        if (s_axi_bready) begin
          s_d.axi = phy_ctrl_pkg::AXI_IDLE;
        end
      end
      phy_ctrl_pkg::AXI_READ_RESP: begin
        if (s_axi_rready) begin
          s_d.axi = phy_ctrl_pkg::AXI_IDLE;
        end
      end
      default: begin
        s_d.axi = phy_ctrl_pkg::AXI_IDLE;
      end
    endcase

    if (write_fire) begin
      case (s_q.aw_index)
        `IDX_RESET_CONTROL: begin
          s_d.rst_spare = 14'(merge({2'h0, s_q.rst_spare}, s_q.wdata[15:0], wmask));
          soft_start = s_q.wstrb[1] && s_q.wdata[`RST_SOFT_BIT];
          dig_start = s_q.wstrb[1] && s_q.wdata[`RST_DIGITAL_BIT];
        end
        `IDX_INDICATOR_CONTROL: s_d.ind_ctrl = merge(s_q.ind_ctrl, s_q.wdata[15:0], wmask);
        `IDX_COMPLIANCE_TEST: s_d.ct_ctrl = merge(s_q.ct_ctrl, s_q.wdata[15:0], wmask);
        default: s_d.rst_spare = s_q.rst_spare;
      endcase
      err_clear = (s_q.aw_index == `IDX_SELF_TEST_ERR) && s_q.wstrb[1] &&
                  s_q.wdata[`SELF_TEST_CLEAR_BIT];
    end

    // a full software reset returns every register to its reset value
    if (s_q.soft_busy) begin
      s_d.ind_ctrl = `IND_CONTROL_RESET;
      s_d.ct_ctrl = `CT_CONTROL_RESET;
      s_d.rst_spare = 14'h0000;
      s_d.strap_wait = 2'h0;
    end

    indicator_out = s_q.ind_ctrl[`IND_POL_BIT] ? indicator_raw : ~indicator_raw;
    s_d.col_out = (s_q.ind_ctrl[`IND_ROUTE_LSB +: 2] == `IND_ROUTE_COL) ?
                  indicator_out : 1'b0;
    s_d.pin_out = (s_q.ind_ctrl[`IND_ROUTE_LSB +: 2] == `IND_ROUTE_PIN) ?
                  indicator_out : 1'b0;
  end

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign s_axi_awready = s_q.aw_held;
  assign s_axi_wready = s_q.w_held;
  assign s_axi_bvalid = (s_q.axi == phy_ctrl_pkg::AXI_WRITE_RESP);
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = (s_q.axi == phy_ctrl_pkg::AXI_READ_RESP);
  assign s_axi_rvalid = (s_q.axi == phy_ctrl_pkg::AXI_READ_RESP);
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign transceiver_reset = s_q.soft_busy;
  assign digital_restart = s_q.dig_busy | s_q.soft_busy;
  assign collision_pin = s_q.col_out;
  assign first_indicator_pin = s_q.pin_out;
  assign test_pattern_enable = s_q.ct_ctrl[`CT_ENABLE_BIT];
  assign test_pattern_select = s_q.ct_ctrl[`CT_PATTERN_LSB +: 4];

endmodule : phy_reset_led_test_ctrl
`default_nettype wire

// ==== phy_reset_led_test_ctrl_monitor.sv ====
// checker for the register bus handshake, reset pulse and indicator pins
// assumes it is bound to phy_reset_led_test_ctrl; one clock domain
`timescale 1ns/1ns
`default_nettype none

module phy_reset_led_test_ctrl_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic transceiver_reset,
  input wire logic digital_restart,
  input wire logic collision_pin,
  input wire logic first_indicator_pin
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // --------------------------------------------------------------------------
  // length of the running software reset pulse
  // --------------------------------------------------------------------------
  logic [5:0] run_q;
  logic [5:0] run_d;
  always_comb run_d = transceiver_reset ? run_q + 6'h01 : 6'h00;
  always_ff @(posedge aclk) run_q <= aresetn ? run_d : 6'h00;

  sequence s_wr_done;
    s_axi_bvalid && s_axi_bready;
  endsequence
  sequence s_rd_done;
    s_axi_rvalid && s_axi_rready;
  endsequence

  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped or changed before bready");
  a_write_retires: assert property (s_wr_done |=> !s_axi_bvalid)
    else $error("bvalid still high after the response was taken");
  a_read_retires: assert property (s_rd_done |=> !s_axi_rvalid)
    else $error("rvalid still high after the data was taken");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped or changed before rready");
  a_ar_with_r: assert property (s_axi_arready == s_axi_rvalid)
    else $error("arready and rvalid disagree");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper half of read data not zero");
  a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready longer than one cycle");
  a_reset_length: assert property ($fell(transceiver_reset) |-> run_q == 6'h10)
    else $error("software reset pulse not 16 cycles");
  a_reset_restarts: assert property (transceiver_reset |-> digital_restart)
    else $error("full reset without digital restart");
  a_one_pin: assert property (!(collision_pin && first_indicator_pin))
    else $error("indicator driven on both pins");
endmodule : phy_reset_led_test_ctrl_monitor

`default_nettype wire

// ==== phy_reset_led_test_ctrl_tb.sv ====
// self-checking bench for the reset, indicator and compliance test bank
// assumes the design files and phy_ctrl_defs.svh are compiled before it
`timescale 1ns/1ns
`default_nettype none
`include "phy_ctrl_defs.svh"
`define CHECK(g, e, m) begin compares++; if ((g) !== (e)) begin fail_count++; $display("CHECK FAILED at %0t: %s", $time, m); end end

module phy_reset_led_test_ctrl_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, polarity_strap = 1'b1;
  phy_ctrl_pkg::phy_status_type phy_status = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic transceiver_reset, digital_restart, collision_pin, first_indicator_pin;
  logic test_pattern_enable;
  logic [3:0] test_pattern_select;
  int compares = 0;
  int fail_count = 0;
  int cycles = 0;
  logic [3:0] codes [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hb, 4'hc};

  phy_reset_led_test_ctrl i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .polarity_strap(polarity_strap),
    .phy_status(phy_status), .transceiver_reset(transceiver_reset),
    .digital_restart(digital_restart), .collision_pin(collision_pin),
    .first_indicator_pin(first_indicator_pin), .test_pattern_enable(test_pattern_enable),
    .test_pattern_select(test_pattern_select));

  always #10 aclk = ~aclk;

  // --------------------------------------------------------------------------
  // bus master; slave answer times are never assumed, the watchdog bounds them
  // --------------------------------------------------------------------------
  task automatic axi_write(input logic [7:0] idx, input logic [15:0] d, output logic [1:0] r);
    logic aw_left;
    logic w_left;
    aw_left = 1'b1;
    w_left = 1'b1;
    s_axi_awaddr <= {22'h0, idx, 2'h0};
    s_axi_wdata <= {16'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (aw_left || w_left) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) begin
        aw_left = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1) begin
        w_left = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    // a late bready exercises the slave holding its response
    repeat ($urandom_range(2)) @(posedge aclk);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : axi_write

  task automatic axi_read(input logic [7:0] idx, output logic [15:0] d, output logic [1:0] r);
    s_axi_araddr <= {22'h0, idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    @(posedge aclk);
    while (s_axi_arready !== 1'b1) @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    repeat ($urandom_range(2)) @(posedge aclk);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    d = s_axi_rdata[15:0];
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : axi_read

  // --------------------------------------------------------------------------
  // expectations
  // --------------------------------------------------------------------------
  function automatic logic source_level(input logic [3:0] s, input phy_ctrl_pkg::phy_status_type p);
    case (s)
      4'h0: return p.link_good;
      4'h1: return p.rx_active | p.tx_active;
      4'h2: return p.tx_active;
      4'h3: return p.rx_active;
      4'h4: return p.collision;
      4'h5: return p.speed_100;
      4'h6: return ~p.speed_100;
      4'h7: return p.full_duplex;
      4'hb: return p.low_power_idle;
      default: return p.mii_error;
    endcase
  endfunction : source_level

  function automatic logic [1:0] exp_pins(input logic on, input logic pol, input logic [1:0] rt);
    logic lvl;
    lvl = pol ? on : ~on;
    return {rt == 2'h0 ? lvl : 1'b0, rt == 2'h3 ? lvl : 1'b0};
  endfunction : exp_pins

  task automatic print_verdict();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      print_verdict();
    end
  end

  // --------------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------------
  initial begin
    logic [15:0] d;
    logic [1:0] r;
    logic [1:0] rt;
    logic [3:0] src;
    logic pol;
    logic saw;
    void'($urandom(72258));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_read(`IDX_RESET_CONTROL, d, r);
    `CHECK(d, 16'h0000, "reset control value")
    axi_read(`IDX_INDICATOR_CONTROL, d, r);
    `CHECK(d, 16'h0000, "indicator control with strap high")
    axi_read(`IDX_COMPLIANCE_TEST, d, r);
    `CHECK(d, 16'h0000, "compliance value")
    axi_read(8'h80, d, r);
    `CHECK(r, 2'h2, "unmapped read response")
    axi_write(8'h80, 16'hffff, r);
    `CHECK(r, 2'h2, "unmapped write response")
    for (int i = 0; i < 24; i++) begin
      src = codes[i % 10];
      pol = 1'($urandom);
      rt = 2'(i);
      axi_write(`IDX_INDICATOR_CONTROL, {6'h0, pol, 2'h0, src, 1'b0, rt}, r);
      phy_status <= 9'($urandom);
      repeat (8) @(posedge aclk);
      `CHECK({collision_pin, first_indicator_pin}, exp_pins(source_level(src, phy_status), pol, rt), "indicator pins")
      axi_read(`IDX_INDICATOR_CONTROL, d, r);
      `CHECK(d & 16'h027b, {6'h0, pol, 2'h0, src, 1'b0, rt}, "indicator readback")
    end
    axi_write(8'h00, 16'h2100, r);
    // no harmonics measurement here, so repetitive patterns are allowed
    for (int i = 0; i < 13; i++) begin
      axi_write(`IDX_COMPLIANCE_TEST, {11'h0, 1'(i), 4'(i)}, r);
      `CHECK({test_pattern_enable, test_pattern_select}, {1'(i), 4'(i)}, "test pattern outputs")
    end
    // link lost, active high, on the indicator pin
    phy_status <= 9'h100;
    axi_write(`IDX_INDICATOR_CONTROL, 16'h026b, r);
    repeat (8) @(posedge aclk);
    axi_read(`IDX_STATUS_BASIC, d, r);
    repeat (8) @(posedge aclk);
    `CHECK(first_indicator_pin, 1'b0, "link lost idle")
    phy_status <= 9'h000;
    repeat (8) @(posedge aclk);
    phy_status <= 9'h100;
    repeat (8) @(posedge aclk);
    `CHECK(first_indicator_pin, 1'b1, "link lost latched")
    axi_read(`IDX_STATUS_BASIC, d, r);
    repeat (8) @(posedge aclk);
    `CHECK(first_indicator_pin, 1'b0, "link lost cleared by read")
    axi_write(`IDX_INDICATOR_CONTROL, 16'h0273, r);
    phy_status <= 9'h101;
    repeat (4) @(posedge aclk);
    phy_status <= 9'h100;
    repeat (8) @(posedge aclk);
    `CHECK(first_indicator_pin, 1'b1, "pattern error latched")
    axi_write(`IDX_SELF_TEST_ERR, 16'h8000, r);
    repeat (8) @(posedge aclk);
    `CHECK(first_indicator_pin, 1'b0, "pattern error cleared")
    axi_write(`IDX_COMPLIANCE_TEST, 16'h0015, r);
    axi_write(`IDX_RESET_CONTROL, 16'h4000, r);
    axi_read(`IDX_RESET_CONTROL, d, r);
    `CHECK(d, 16'h4000, "restart busy reads one")
    while (digital_restart === 1'b1) @(posedge aclk);
    axi_read(`IDX_RESET_CONTROL, d, r);
    `CHECK(d, 16'h0000, "restart bit cleared")
    axi_read(`IDX_COMPLIANCE_TEST, d, r);
    `CHECK(d, 16'h0015, "restart keeps registers")
    // strap low now, so the full reset must reload active high polarity
    polarity_strap <= 1'b0;
    axi_write(`IDX_RESET_CONTROL, 16'h8000, r);
    saw = transceiver_reset;
    while (transceiver_reset === 1'b1) @(posedge aclk);
    `CHECK(saw, 1'b1, "software reset ran")
    repeat (4) @(posedge aclk);
    axi_read(`IDX_COMPLIANCE_TEST, d, r);
    `CHECK(d, 16'h0000, "full reset clears registers")
    axi_read(`IDX_INDICATOR_CONTROL, d, r);
    `CHECK(d, 16'h0200, "polarity from low strap")
    axi_read(`IDX_RESET_CONTROL, d, r);
    `CHECK(d, 16'h0000, "software reset bit cleared")
    print_verdict();
  end
endmodule : phy_reset_led_test_ctrl_tb

bind phy_reset_led_test_ctrl phy_reset_led_test_ctrl_monitor i_mon (.aclk(aclk),
  .aresetn(aresetn), .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .transceiver_reset(transceiver_reset), .digital_restart(digital_restart),
  .collision_pin(collision_pin), .first_indicator_pin(first_indicator_pin));

`default_nettype wire
